// >>> rtl/psm_defines.svh
// Constants of the power-saving mode controller: widths, reset values, addresses.
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// ==========================================================================
// Control field layout and reset values
// ==========================================================================
`define PSM_RATIO_W 3
`define PSM_CTL_RST 7'h00
`define PSM_DOZE_RATIO_MIN 3'h1

// ==========================================================================
// Status flags after reset (both active low, both inactive)
// ==========================================================================
`define PSM_SLEEP_EXECUTED_N_RST 1'h1
`define PSM_WATCHDOG_EXPIRY_N_RST 1'h1

// ==========================================================================
// Program addresses
// ==========================================================================
`define PSM_PC_W 16
`define PSM_ISR_VECTOR 16'h0004
`define PSM_PREFETCH_STEP 16'h0002

`endif

// >>> rtl/psm_pkg.sv
// Types shared by the power-saving mode controller.
`include "psm_defines.svh"

package psm_pkg;

	// ==========================================================================
	// Software control word
	// ==========================================================================
	typedef struct packed {
		logic idle_select;
		logic doze_active_flag;
		logic recover_on_interrupt;
		logic slow_after_isr_return;
		logic [`PSM_RATIO_W-1:0] ratio;
	} psm_ctl_t;

	// ==========================================================================
	// Reset sources, readiness conditions and kept-alive clocks
	// ==========================================================================
	typedef struct packed {
		logic external_reset_pin;
		logic supply_drop_reset;
		logic lowpower_supply_drop_reset;
		logic watchdog;
	} psm_rst_src_t;

	typedef struct packed {
		logic program_flash;
		logic system_clock;
		logic supply_drop;
		logic supply_drop_enabled;
	} psm_ready_t;

	typedef struct packed {
		logic low_freq_osc;
		logic high_freq_osc;
		logic converter_rc_osc;
		logic band_gap;
	} psm_osc_t;

	typedef enum logic [1:0] {
		PSM_RUN,
		PSM_SLEEP,
		PSM_IDLE,
		PSM_WAKE_WAIT
	} psm_state_t;

endpackage : psm_pkg

// >>> rtl/psm_doze_div.sv
// Doze cycle divider: one CPU cycle out of every 2 << ratio system cycles.
`include "psm_defines.svh"
module psm_doze_div
	import psm_pkg::*;
#(
	parameter int RATIO_W = `PSM_RATIO_W,
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Control
	input wire logic enable_i,
	input wire logic [RATIO_W-1:0] ratio_i,
	// Result
	output logic tick_o
);

	// ==========================================================================
	// Cycle counter
	// ==========================================================================
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] last;

	always_comb begin
		last = CNT_W'((2 << ratio_i) - 1);
		count_d = count_q;
		// Held at zero when off so the first doze cycle is an executing one.
		if (!enable_i) begin
			count_d = '0;
		end else if (count_q >= last) begin
			count_d = '0;
		end else begin
			count_d = count_q + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign tick_o = (count_q == '0);

endmodule : psm_doze_div

// >>> rtl/psm_ctrl.sv
// Power-saving mode controller: doze, sleep, idle, wake-up and resume gating.
`include "psm_defines.svh"
module psm_ctrl
	import psm_pkg::*;
#(
	parameter int IRQ_W = 8,
	parameter int CLK_SWITCH_IDX = 0,
	parameter int PC_W = `PSM_PC_W
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Software control word
	input wire logic ctl_wr_i,
	input wire psm_ctl_t ctl_wdata_i,
	output psm_ctl_t ctl_rdata_o,
	// CPU pipeline events
	input wire logic sleep_exec_i,
	input wire logic isr_entry_i,
	input wire logic isr_return_i,
	input wire logic multicycle_busy_i,
	input wire logic prefetch_clears_global_i,
	input wire logic [PC_W-1:0] pc_i,
	// Interrupt sources
	input wire logic [IRQ_W-1:0] irq_flag_i,
	input wire logic [IRQ_W-1:0] irq_enable_regs_i,
	input wire logic global_irq_allow_i,
	// Reset sources and watchdog
	input wire psm_rst_src_t rst_src_i,
	input wire psm_rst_src_t rst_src_en_i,
	input wire logic wdt_run_in_sleep_i,
	// Readiness after wake
	input wire psm_ready_t ready_i,
	// CPU gating
	output logic cpu_clk_en_o,
	output logic cpu_exec_en_o,
	output logic fetch_en_o,
	output logic isr_take_o,
	output logic [PC_W-1:0] fetch_addr_o,
	// Peripheral side
	output logic periph_clk_en_o,
	output psm_osc_t osc_run_o,
	output logic io_hold_o,
	// Watchdog and reset
	output logic wdt_clear_o,
	output logic wdt_run_o,
	output logic device_reset_o,
	// Status
	output logic sleep_executed_n_o,
	output logic watchdog_expiry_flag_n_o,
	output psm_state_t mode_o
);

	// ==========================================================================
	// Interrupt qualification
	// ==========================================================================
	logic [IRQ_W-1:0] wake_mask;
	logic irq_pend;

	always_comb begin
		wake_mask = '1;
		wake_mask[CLK_SWITCH_IDX] = 1'b0;
	end

	// The source enables and the clock-switch mask decide; the global enable is not looked at.
	assign irq_pend = |(irq_flag_i & irq_enable_regs_i & wake_mask);

	// ==========================================================================
	// Doze divider
	// ==========================================================================
	psm_ctl_t ctl_q;
	psm_ctl_t ctl_d;
	logic doze_tick;

	psm_doze_div #(
		.RATIO_W(`PSM_RATIO_W),
		.CNT_W(9)
	) u_div (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.enable_i(ctl_q.doze_active_flag),
		.ratio_i(ctl_q.ratio),
		.tick_o(doze_tick)
	);

	// ==========================================================================
	// Mode state and pipeline gating
	// ==========================================================================
	psm_state_t state_q;
	psm_state_t state_d;
	logic post_wake_q;
	logic post_wake_d;
	logic [PC_W-1:0] fetch_addr_q;
	logic [PC_W-1:0] fetch_addr_d;
	logic run;
	logic sys_ready;
	logic sleep_go;
	logic wake;
	logic wdt_wake;

	assign run = (state_q == PSM_RUN);
	assign sys_ready = ready_i.program_flash && ready_i.system_clock &&
		(ready_i.supply_drop || !ready_i.supply_drop_enabled);

	// Outside doze every Run cycle executes; in doze only the divider tick does.
	assign cpu_exec_en_o = run && (!ctl_q.doze_active_flag || doze_tick);
	assign fetch_en_o = cpu_exec_en_o;
	assign cpu_clk_en_o = run;

	// A pending source turns the sleep instruction into a no-operation.
	assign sleep_go = sleep_exec_i && cpu_exec_en_o && !irq_pend;

	// Vector fetch waits for a multicycle instruction and for the one
	// instruction owed after a wake; a prefetched global disable cancels it.
	assign isr_take_o = cpu_exec_en_o && irq_pend && global_irq_allow_i &&
		!multicycle_busy_i && !post_wake_q && !prefetch_clears_global_i;

	// In Idle the watchdog wakes rather than resets.
	assign wdt_wake = (state_q == PSM_IDLE) && rst_src_i.watchdog &&
		rst_src_en_i.watchdog;
	assign wake = ((state_q == PSM_SLEEP) || (state_q == PSM_IDLE)) &&
		(irq_pend || wdt_wake);

	always_comb begin
		state_d = state_q;
		post_wake_d = post_wake_q;
		fetch_addr_d = fetch_addr_q;
		unique case (state_q)
			PSM_RUN: begin
				if (sleep_go) begin
					// The mode is picked from idle select as it stands now.
					state_d = ctl_q.idle_select ? PSM_IDLE : PSM_SLEEP;
				end
				if (cpu_exec_en_o) begin
					post_wake_d = 1'b0;
				end
			end
			PSM_SLEEP, PSM_IDLE: begin
				if (wake) begin
					state_d = PSM_WAKE_WAIT;
				end
			end
			PSM_WAKE_WAIT: begin
				if (sys_ready) begin
					state_d = PSM_RUN;
					post_wake_d = 1'b1;
				end
			end
		endcase
		if (isr_take_o) begin
			fetch_addr_d = PC_W'(`PSM_ISR_VECTOR);
		end else if (cpu_exec_en_o) begin
			fetch_addr_d = PC_W'(pc_i + `PSM_PREFETCH_STEP);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= PSM_RUN;
			post_wake_q <= 1'b0;
			fetch_addr_q <= '0;
		end else begin
			state_q <= state_d;
			post_wake_q <= post_wake_d;
			fetch_addr_q <= fetch_addr_d;
		end
	end

	// ==========================================================================
	// Control word with hardware set and clear of the doze flag
	// ==========================================================================
	logic doze_clr;
	logic doze_set;

	// A prefetched global disable still drops to full speed when an interrupt hits.
	assign doze_clr = ctl_q.recover_on_interrupt &&
		(isr_entry_i || (cpu_exec_en_o && irq_pend && global_irq_allow_i &&
		prefetch_clears_global_i));
	// The exit bit is read at the return itself, so a write inside the
	// service routine takes effect on that return.
	assign doze_set = isr_return_i && ctl_q.slow_after_isr_return;

	always_comb begin
		ctl_d = ctl_q;
		if (ctl_wr_i) begin
			ctl_d = ctl_wdata_i;
		end
		if (doze_clr) begin
			ctl_d.doze_active_flag = 1'b0;
		end
		// Hardware set wins over both clear and software write.
		if (doze_set) begin
			ctl_d.doze_active_flag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_q <= `PSM_CTL_RST;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// ==========================================================================
	// Status flags
	// ==========================================================================
	logic slept_n_q;
	logic slept_n_d;
	logic expiry_n_q;
	logic expiry_n_d;

	always_comb begin
		slept_n_d = slept_n_q;
		expiry_n_d = expiry_n_q;
		if (rst_src_i.watchdog && rst_src_en_i.watchdog) begin
			expiry_n_d = 1'b0;
		end
		if (sleep_go && !ctl_q.idle_select) begin
			slept_n_d = 1'b0;
			expiry_n_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			slept_n_q <= `PSM_SLEEP_EXECUTED_N_RST;
			expiry_n_q <= `PSM_WATCHDOG_EXPIRY_N_RST;
		end else begin
			slept_n_q <= slept_n_d;
			expiry_n_q <= expiry_n_d;
		end
	end

	// ==========================================================================
	// Watchdog, resets and kept clocks
	// ==========================================================================
	psm_rst_src_t rst_hit;

	always_comb begin
		rst_hit = rst_src_i & rst_src_en_i;
		// Only the watchdog changes with mode; the rest pass untouched.
		if (state_q == PSM_IDLE) begin
			rst_hit.watchdog = 1'b0;
		end
	end

	assign device_reset_o = |rst_hit;

	assign wdt_clear_o = (sleep_go && !ctl_q.idle_select) ||
		((state_q == PSM_SLEEP) && wake);
	assign wdt_run_o = (state_q != PSM_SLEEP) || wdt_run_in_sleep_i;

	// Doze and Idle touch only the CPU and flash; Sleep stops system clocks.
	assign periph_clk_en_o = (state_q != PSM_SLEEP);
	assign io_hold_o = (state_q == PSM_SLEEP);

	always_comb begin
		osc_run_o.low_freq_osc = 1'b1;
		osc_run_o.high_freq_osc = 1'b1;
		osc_run_o.converter_rc_osc = 1'b1;
		osc_run_o.band_gap = (state_q != PSM_SLEEP);
	end

	// ==========================================================================
	// Register outputs
	// ==========================================================================
	assign ctl_rdata_o = ctl_q;
	assign fetch_addr_o = fetch_addr_q;
	assign sleep_executed_n_o = slept_n_q;
	assign watchdog_expiry_flag_n_o = expiry_n_q;
	assign mode_o = state_q;

endmodule : psm_ctrl

// >>> verification/psm_cpu_model.sv
// Behavioural model of the CPU pipeline facing the power-saving controller.
module psm_cpu_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Controller outputs
	input wire logic exec_i,
	input wire logic take_i,
	// Pipeline events
	output logic entry_o,
	output logic [15:0] pc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic exec_q;
	logic take_q;
	// Sampled on the rising edge and applied on the falling one, so the model never races the controller.
	always_ff @(posedge sys_clk_i) begin
		exec_q <= exec_i;
		take_q <= take_i;
	end
	always_ff @(negedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			entry_o <= 1'h0;
			pc_o <= 16'h0100;
		end else begin
			entry_o <= take_q;
			if (take_q) begin
				pc_o <= 16'h0004;
			end else if (exec_q) begin
				// The word after a sleep is a plain step with no events of its own.
				pc_o <= pc_o + 16'h0002;
			end
		end
	end
endmodule : psm_cpu_model

// >>> verification/psm_ctrl_sva.sv
// Assertion checker for the power-saving mode controller.
module psm_ctrl_sva
	import psm_pkg::*;
#(
	parameter int IRQ_W = 8,
	parameter int CLK_SWITCH_IDX = 0,
	parameter int PC_W = 16
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Watched inputs
	input wire logic sleep_exec_i,
	input wire logic isr_entry_i,
	input wire logic isr_return_i,
	input wire logic multicycle_busy_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic [IRQ_W-1:0] irq_flag_i,
	input wire logic [IRQ_W-1:0] irq_enable_regs_i,
	input wire psm_rst_src_t rst_src_i,
	input wire psm_rst_src_t rst_src_en_i,
	input wire psm_ready_t ready_i,
	// Watched outputs
	input wire psm_ctl_t ctl_rdata_o,
	input wire psm_state_t mode_o,
	input wire logic [PC_W-1:0] fetch_addr_o,
	input wire logic cpu_clk_en_o,
	input wire logic cpu_exec_en_o,
	input wire logic fetch_en_o,
	input wire logic isr_take_o,
	input wire logic periph_clk_en_o,
	input wire logic io_hold_o,
	input wire logic wdt_clear_o,
	input wire logic wdt_run_o,
	input wire logic sleep_executed_n_o,
	input wire logic watchdog_expiry_flag_n_o,
	input wire logic device_reset_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================================
	// Helpers
	// ==========================================================================
	logic [IRQ_W-1:0] wake_src;
	logic ready_all;
	assign wake_src = irq_flag_i & irq_enable_regs_i & ~(IRQ_W'(1) << CLK_SWITCH_IDX);
	assign ready_all = ready_i.program_flash & ready_i.system_clock & (ready_i.supply_drop | ~ready_i.supply_drop_enabled);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	// ==========================================================================
	// Properties
	// ==========================================================================
	sleep_entry_a: assert property (sleep_exec_i && cpu_exec_en_o && !ctl_rdata_o.idle_select
		&& !(|(irq_flag_i & irq_enable_regs_i)) |-> wdt_clear_o
		##1 mode_o == PSM_SLEEP && !sleep_executed_n_o && watchdog_expiry_flag_n_o) else $error("sleep entry");
	sleep_hold_a: assert property (mode_o == PSM_SLEEP |-> !cpu_clk_en_o && io_hold_o) else $error("sleep hold");
	periph_run_a: assert property (mode_o != PSM_SLEEP |-> periph_clk_en_o) else $error("periph clock");
	irq_wake_a: assert property (mode_o == PSM_SLEEP && |wake_src
		|-> wdt_clear_o ##1 mode_o == PSM_WAKE_WAIT) else $error("irq wake");
	wake_go_a: assert property (mode_o == PSM_WAKE_WAIT && ready_all |=> mode_o == PSM_RUN) else $error("wake go");
	first_insn_a: assert property (mode_o == PSM_RUN && $past(mode_o) == PSM_WAKE_WAIT |-> !isr_take_o)
		else $error("first insn");
	isr_vector_a: assert property (isr_take_o |-> !multicycle_busy_i ##1 fetch_addr_o == 16'h0004)
		else $error("isr vector");
	prefetch_addr_a: assert property (cpu_exec_en_o && !isr_take_o |=> fetch_addr_o == $past(pc_i) + 16'h0002)
		else $error("prefetch");
	recover_clear_a: assert property (isr_entry_i && ctl_rdata_o.recover_on_interrupt
		&& !(isr_return_i && ctl_rdata_o.slow_after_isr_return) |=> !ctl_rdata_o.doze_active_flag)
		else $error("recover clear");
	exit_set_a: assert property (isr_return_i && ctl_rdata_o.slow_after_isr_return
		|=> ctl_rdata_o.doze_active_flag) else $error("exit set");
	reset_src_a: assert property (|(rst_src_i & rst_src_en_i & 4'hE) |-> device_reset_o) else $error("reset");
	fetch_run_a: assert property (cpu_exec_en_o |-> fetch_en_o) else $error("fetch run");
	wdt_awake_a: assert property (mode_o != PSM_SLEEP |-> wdt_run_o) else $error("wdt awake");
	idle_entry_a: assert property (sleep_exec_i && cpu_exec_en_o && ctl_rdata_o.idle_select
		&& !(|wake_src) |=> mode_o == PSM_IDLE) else $error("idle entry");
endmodule : psm_ctrl_sva

bind psm_ctrl psm_ctrl_sva #(.IRQ_W(IRQ_W), .CLK_SWITCH_IDX(CLK_SWITCH_IDX), .PC_W(PC_W)) chk_i (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.sleep_exec_i(sleep_exec_i),
	.isr_entry_i(isr_entry_i),
	.isr_return_i(isr_return_i),
	.multicycle_busy_i(multicycle_busy_i),
	.pc_i(pc_i),
	.irq_flag_i(irq_flag_i),
	.irq_enable_regs_i(irq_enable_regs_i),
	.rst_src_i(rst_src_i),
	.rst_src_en_i(rst_src_en_i),
	.ready_i(ready_i),
	.ctl_rdata_o(ctl_rdata_o),
	.mode_o(mode_o),
	.fetch_addr_o(fetch_addr_o),
	.cpu_clk_en_o(cpu_clk_en_o),
	.cpu_exec_en_o(cpu_exec_en_o),
	.fetch_en_o(fetch_en_o),
	.isr_take_o(isr_take_o),
	.periph_clk_en_o(periph_clk_en_o),
	.io_hold_o(io_hold_o),
	.wdt_clear_o(wdt_clear_o),
	.wdt_run_o(wdt_run_o),
	.sleep_executed_n_o(sleep_executed_n_o),
	.watchdog_expiry_flag_n_o(watchdog_expiry_flag_n_o),
	.device_reset_o(device_reset_o)
);

// >>> verification/psm_ctrl_tb.sv
// Self-checking testbench for the power-saving mode controller.
module psm_ctrl_tb
	import psm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, sx = 1'h0, ret = 1'h0, mb = 1'h0, pcg = 1'h0, gen = 1'h0, wrs = 1'h1;
	logic ent, ce, xe, tk, pe, ih, wro, dr, pdn, ton, seen;
	logic [7:0] fl = 8'h00, en = 8'h00;
	logic [15:0] pc, fa;
	psm_ctl_t wd = 7'h00, rd;
	psm_rst_src_t rs = 4'h0, re = 4'hF;
	psm_ready_t rdy = 4'hF;
	psm_osc_t osc;
	psm_state_t md;
	int mismatches = 0, total_checks = 0, cyc = 0, n;
	psm_ctrl dut (.sys_clk_i(clk), .rst_i(rst), .ctl_wr_i(wr), .ctl_wdata_i(wd), .ctl_rdata_o(rd),
		.sleep_exec_i(sx), .isr_entry_i(ent), .isr_return_i(ret), .multicycle_busy_i(mb),
		.prefetch_clears_global_i(pcg), .pc_i(pc), .irq_flag_i(fl), .irq_enable_regs_i(en), .global_irq_allow_i(gen),
		.rst_src_i(rs), .rst_src_en_i(re), .wdt_run_in_sleep_i(wrs), .ready_i(rdy), .cpu_clk_en_o(ce),
		.cpu_exec_en_o(xe), .fetch_en_o(), .isr_take_o(tk), .fetch_addr_o(fa), .periph_clk_en_o(pe),
		.osc_run_o(osc), .io_hold_o(ih), .wdt_clear_o(), .wdt_run_o(wro), .device_reset_o(dr),
		.sleep_executed_n_o(pdn), .watchdog_expiry_flag_n_o(ton), .mode_o(md));
	psm_cpu_model cpu (.sys_clk_i(clk), .rst_i(rst), .exec_i(xe), .take_i(tk), .entry_o(ent), .pc_o(pc));
	// ==========================================================================
	// Clock, watchdog on the run and tasks
	// ==========================================================================
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	task tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// A write leaves one idle cycle behind it, so back-to-back calls never retoggle the strobe.
	task wctl(input psm_ctl_t v);
		wd = v;
		wr = 1'h1;
		tick(1);
		wr = 1'h0;
		tick(1);
	endtask : wctl
	task slp();
		sx = 1'h1;
		tick(1);
		sx = 1'h0;
	endtask : slp
	task waitx();
		n = 0;
		while (xe !== 1'h1 && n < 300) begin
			tick(1);
			n++;
		end
	endtask : waitx
	task waitd();
		seen = 1'h0;
		n = 0;
		while (rd.doze_active_flag !== 1'h0 && n < 40) begin
			tick(1);
			seen |= tk;
			n++;
		end
	endtask : waitd
	task wrap_up();
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	// ==========================================================================
	// Sequence
	// ==========================================================================
	initial begin
		tick(8);
		rst = 1'h0;
		tick(1);
		chk("expiry_n", 16'h0001, ton);
		for (int r = 0; r < 8; r++) begin
			wctl(7'h00);
			wctl({4'h4, 3'(r)});
			waitx();
			tick(1);
			chk("periph", 16'h0001, pe);
			waitx();
			chk("gap", 16'(2 << r), 16'(n + 1));
		end
		wctl(7'h31);
		mb = 1'h1;
		gen = 1'h1;
		en = 8'h06;
		fl = 8'h02;
		tick(10);
		chk("busy", 16'h0001, rd.doze_active_flag);
		mb = 1'h0;
		waitd();
		chk("recover", 16'h0000, rd.doze_active_flag);
		chk("vector", 16'h0004, fa);
		fl = 8'h00;
		wctl(7'h19);
		chk("exit_doze", 16'h0000, rd.doze_active_flag);
		ret = 1'h1;
		tick(1);
		ret = 1'h0;
		chk("exit_doze", 16'h0001, rd.doze_active_flag);
		wctl(7'h31);
		pcg = 1'h1;
		fl = 8'h02;
		waitd();
		chk("pf_global", 16'h0000, rd.doze_active_flag);
		chk("no_isr", 16'h0000, seen);
		pcg = 1'h0;
		fl = 8'h00;
		gen = 1'h0;
		wctl(7'h00);
		slp();
		chk("mode", PSM_SLEEP, md);
		chk("slept_n", 16'h0000, pdn);
		chk("hold", 16'h0001, ih);
		chk("cpu_clk", 16'h0000, ce);
		chk("wdt_run", 16'h0001, wro);
		chk("osc", 16'h000E, osc);
		wrs = 1'h0;
		en = 8'h05;
		fl = 8'h01;
		tick(3);
		chk("wdt_run", 16'h0000, wro);
		chk("mode", PSM_SLEEP, md);
		rdy = 4'hD;
		fl = 8'h05;
		tick(1);
		gen = 1'h1;
		tick(3);
		chk("mode", PSM_WAKE_WAIT, md);
		rdy = 4'hC;
		tick(1);
		chk("isr", 16'h0000, tk);
		tick(1);
		chk("isr", 16'h0001, tk);
		fl = 8'h00;
		gen = 1'h0;
		wctl(7'h40);
		slp();
		chk("mode", PSM_IDLE, md);
		wctl(7'h00);
		chk("mode", PSM_IDLE, md);
		rs = 4'h1;
		tick(2);
		chk("mode", PSM_RUN, md);
		rs = 4'h8;
		tick(1);
		chk("reset", 16'h0001, dr);
		wrap_up();
	end
endmodule : psm_ctrl_tb
